// ==== dv/odi_op_partner.sv ====
// odi_op_partner: stack-building side that takes interrupt reports
// assumes irq_valid stands until acknowledged; ack_delay sets prompt or slow answers
`timescale 1ns/1ps
module odi_op_partner (
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       rst_n,
   // report handshake
   input  wire logic       irq_valid,
   input  wire logic [3:0] ack_delay,
   output logic            report_ack
);
   logic [3:0] wait_cnt;

   // for ack_delay below 15, one acknowledge per report, ack_delay+1 cycles after it appears
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wait_cnt   <= 4'h0;
         report_ack <= 1'b0;
      end else begin
         report_ack <= 1'b0;
         if (!irq_valid) begin
            wait_cnt <= 4'h0;
         end else if (wait_cnt != 4'hF) begin
            wait_cnt <= wait_cnt + 4'h1;
            if (wait_cnt == ack_delay) begin
               report_ack <= 1'b1;
            end
         end
      end
   end
endmodule

// ==== dv/tb_top.sv ====
// tb_top: directed checks of interrupt detection and parameter formatting
// assumes odi_detect as top, event strobes one cycle long, report acked by partner
`timescale 1ns/1ps
module tb_top;
   logic mclk, rst_n, ce, op_busy, op_start, ptr_adjusted, mem_write_req;
   logic proc_transfer, code_absent, display_update, desc_absent, code_fetch_req;
   logic data_absent, mark_access, str_active, rd_valid, proc_idle, test_fail;
   logic report_ack, irq_valid, code_fetch_grant, mem_write_grant, test_run;
   logic [15:0]              op_code, timer_preset;
   logic [2:0]               mark_tag;
   logic [48:0]              rd_word;
   logic [8:0]               str_keep_words;
   logic [19:0]              stack_top_address, stack_limit_address;
   logic [47:0]              test_detail;
   logic [3:0]               ack_delay;
   odi_pkg::odi_ptr_t        op_ptr, invoke_ptr;
   odi_pkg::odi_report_t     report;
   int                       mismatches = 0;
   int                       n_tests = 0;

   odi_detect dut (.mclk, .rst_n, .ce, .op_busy, .op_start, .op_code, .op_ptr,
      .ptr_adjusted, .mem_write_req, .proc_transfer, .code_absent, .display_update,
      .desc_absent, .invoke_ptr, .code_fetch_req, .data_absent, .mark_access, .mark_tag,
      .str_active, .rd_valid, .rd_word, .str_keep_words, .timer_preset, .stack_top_address,
      .stack_limit_address, .proc_idle, .test_fail, .test_detail, .report_ack, .irq_valid,
      .report, .code_fetch_grant, .mem_write_grant, .test_run);
   odi_op_partner partner (.mclk, .rst_n, .irq_valid, .ack_delay, .report_ack);

   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // advance n cycles, dropping every event strobe after the first edge
   task automatic step(input int n);
      repeat (n) begin
         @(posedge mclk);
         #1;
         op_start = 1'b0;
         proc_transfer = 1'b0;
         display_update = 1'b0;
         data_absent = 1'b0;
         mark_access = 1'b0;
         rd_valid = 1'b0;
         test_fail = 1'b0;
      end
   endtask

   task automatic wait_irq(output int n);
      n = 0;
      while (irq_valid !== 1'b1 && n < 20) begin
         step(1);
         n++;
      end
   endtask

   task automatic expect_irq(input odi_pkg::odi_cause_t c);
      int n;
      wait_irq(n);
      chk("irq_valid", irq_valid, 1'b1);
      chk("cause", report.cause, c);
   endtask

   task automatic wait_clear;
      int k;
      k = 0;
      while (irq_valid !== 1'b0 && k < 20) begin
         step(1);
         k++;
      end
      chk("irq_clear", irq_valid, 1'b0);
   endtask

   // close the operator so a held fault is released
   task automatic finish_op;
      wait_clear();
      op_busy = 1'b0;
      step(2);
      op_busy = 1'b1;
      step(1);
   endtask

   initial begin
      int n;
      {ce, op_busy, op_start, ptr_adjusted, mem_write_req, proc_transfer} = '0;
      {code_absent, display_update, desc_absent, code_fetch_req, data_absent} = '0;
      {mark_access, str_active, rd_valid, proc_idle, test_fail} = '0;
      {op_code, timer_preset, mark_tag, rd_word, str_keep_words, test_detail} = '0;
      op_ptr = '{iwp: 13'h0123, syl: 3'h2};
      invoke_ptr = '{iwp: 13'h05A5, syl: 3'h6};
      stack_top_address = 20'h0_0100;
      stack_limit_address = 20'h0_0200;
      ack_delay = 4'h1;
      rst_n = 1'b0;
      ce = 1'b1;
      repeat (8) @(posedge mclk);
      #1 rst_n = 1'b1;
      step(1);
      op_busy = 1'b1;
      code_fetch_req = 1'b1;
      mem_write_req = 1'b1;
      step(2);
      chk("fetch_grant", code_fetch_grant, 1'b1);
      proc_transfer = 1'b1;
      code_absent = 1'b1;
      step(1);
      expect_irq(odi_pkg::ODI_PRESENCE_PROC);
      chk("rcw_ptr", report.rcw_ptr, invoke_ptr);
      chk("fetch_held", code_fetch_grant, 1'b0);
      code_absent = 1'b0;
      finish_op();
      display_update = 1'b1;
      desc_absent = 1'b1;
      step(1);
      expect_irq(odi_pkg::ODI_PRESENCE_PROC);
      desc_absent = 1'b0;
      finish_op();
      data_absent = 1'b1;
      step(1);
      expect_irq(odi_pkg::ODI_PRESENCE_DATA);
      chk("backed_ptr", report.rcw_ptr, op_ptr);
      finish_op();
      mark_access = 1'b1;
      mark_tag = 3'h3;
      step(3);
      chk("mark_ok", irq_valid, 1'b0);
      ack_delay = 4'h6;
      for (int a = 0; a < 2; a++) begin
         ptr_adjusted = 1'(a);
         mark_access = 1'b1;
         mark_tag = 3'h5;
         step(1);
         expect_irq(odi_pkg::ODI_SEQUENCE);
         chk("p1_bit24", report.p1[24], a == 0);
         chk("p1_bit23", report.p1[23], a == 1);
         finish_op();
      end
      ack_delay = 4'h0;
      str_keep_words = 9'h02A;
      for (int p = 0; p < 2; p++) begin
         str_active = 1'b1;
         for (int w = 0; w < (p == 0 ? 3 : 260); w++) begin
            rd_valid = 1'b1;
            rd_word = {1'b0, 48'hFFFF_FFFF_FFFF};
            step(1);
         end
         chk("seg_quiet", irq_valid, 1'b0);
         rd_valid = 1'b1;
         rd_word = {1'b1, 48'h0000_0000_0000};
         step(1);
         expect_irq(odi_pkg::ODI_SEGMENTED);
         chk("seg_words", report.p1, p == 0 ? 64'h0003 : 64'h0100);
         chk("keep_words", report.p2, 64'h0000_0000_0000_002A);
         str_active = 1'b0;
         finish_op();
      end
      op_start = 1'b1;
      op_code = 16'h9542;
      timer_preset = 16'hFFFE;
      step(8);
      chk("timer_other_op", irq_valid, 1'b0);
      op_start = 1'b1;
      op_code = 16'h9545;
      step(1);
      wait_irq(n);
      chk("timer_cause", report.cause, odi_pkg::ODI_TIMER);
      chk("timer_cycles", 64'(n), 64'h0000_0000_0000_0003);
      finish_op();
      stack_top_address = 20'h0_0200;
      step(1);
      expect_irq(odi_pkg::ODI_STACK_OVF);
      chk("ovf_p1", report.p1, 64'h0000_0000_0000_0200);
      finish_op();
      step(3);
      chk("ovf_once", irq_valid, 1'b0);
      chk("write_open", mem_write_grant, 1'b1);
      data_absent = 1'b1;
      mark_access = 1'b1;
      mark_tag = 3'h1;
      step(1);
      expect_irq(odi_pkg::ODI_PRESENCE_DATA);
      chk("write_held", mem_write_grant, 1'b0);
      wait_clear();
      mark_access = 1'b1;
      step(4);
      chk("second_dropped", irq_valid, 1'b0);
      chk("write_still_held", mem_write_grant, 1'b0);
      finish_op();
      proc_idle = 1'b1;
      step(2);
      chk("test_busy", test_run, 1'b0);
      op_busy = 1'b0;
      step(2);
      chk("test_idle", test_run, 1'b1);
      ce = 1'b0;
      test_fail = 1'b1;
      step(3);
      chk("frozen_irq", irq_valid, 1'b0);
      chk("frozen_run", test_run, 1'b1);
      ce = 1'b1;
      test_fail = 1'b1;
      test_detail = 48'hC0DE_1234_5678;
      step(1);
      expect_irq(odi_pkg::ODI_CONFIDENCE);
      chk("conf_p1", report.p1, 64'h0000_C0DE_1234_5678);
      chk("conf_p2", report.p2, 64'h0000_0000_0000_9545);
      wait_clear();
      end_of_test();
   end

   initial begin
      repeat (3000) @(posedge mclk);
      mismatches++;
      end_of_test();
   end
endmodule

// ==== hw/odi_detect.sv ====
// odi_detect: detection and parameter formatting of operator-dependent interrupts
// assumes operator controllers present one-cycle event strobes and hold op_busy per operator
//
// How it works
// - missing code on enter/exit/return raises interrupt
// - copy invoking word pointers into return word
// - block code fetch of absent segment
// - mark word tag not 3 raises sequence error
// - before adjust bit24, after adjust bit23 only
// - protect bit on string read: segmented array
// - string segments hold at most 256 words
// - second parameter gives words to keep
// - timer preset by 9545, counts up, interrupts
// - stack top equals limit raises overflow
// - idle starts confidence test; failure interrupts
// - confidence failure details into parameter words
// - data-dependent miss backs pointers to operator
`timescale 1ns/1ps
module odi_detect (
   // clock and reset
   input  wire logic                        mclk,
   input  wire logic                        rst_n,
   input  wire logic                        ce,
   // operator sequencing
   input  wire logic                        op_busy,
   input  wire logic                        op_start,
   input  wire logic [15:0]                 op_code,
   input  wire odi_pkg::odi_ptr_t           op_ptr,
   input  wire logic                        ptr_adjusted,
   input  wire logic                        mem_write_req,
   // procedure linkage
   input  wire logic                        proc_transfer,
   input  wire logic                        code_absent,
   input  wire logic                        display_update,
   input  wire logic                        desc_absent,
   input  wire odi_pkg::odi_ptr_t           invoke_ptr,
   input  wire logic                        code_fetch_req,
   // data access
   input  wire logic                        data_absent,
   // mark word access
   input  wire logic                        mark_access,
   input  wire logic [odi_pkg::TAG_W-1:0]   mark_tag,
   // string reads
   input  wire logic                        str_active,
   input  wire logic                        rd_valid,
   input  wire logic [odi_pkg::WORD_W:0]    rd_word,
   input  wire logic [odi_pkg::CNT_W-1:0]   str_keep_words,
   // timer
   input  wire logic [odi_pkg::TIMER_W-1:0] timer_preset,
   // stack
   input  wire logic [odi_pkg::ADDR_W-1:0]  stack_top_address,
   input  wire logic [odi_pkg::ADDR_W-1:0]  stack_limit_address,
   // confidence test
   input  wire logic                        proc_idle,
   input  wire logic                        test_fail,
   input  wire logic [odi_pkg::WORD_W-1:0]  test_detail,
   // report
   input  wire logic                        report_ack,
   output logic                             irq_valid,
   output odi_pkg::odi_report_t             report,
   output logic                             code_fetch_grant,
   output logic                             mem_write_grant,
   output logic                             test_run
);
   typedef struct packed {
      logic                 irq_valid;
      odi_pkg::odi_report_t report;
      logic                 held;
      logic                 fetch_grant;
      logic                 write_grant;
      logic                 test_run;
      logic                 ovf_seen;
   } odi_state_t;

   odi_state_t s;
   odi_state_t next_s;

   logic                      tmr_expired;
   logic                      seg_boundary;
   logic [odi_pkg::CNT_W-1:0] seg_words;

   odi_interval_timer u_timer (
      .mclk    (mclk),
      .rst_n   (rst_n),
      .ce      (ce),
      .op_valid(op_start),
      .op_code (op_code),
      .preset  (timer_preset),
      .expired (tmr_expired)
   );

   odi_segment_check u_seg (
      .mclk      (mclk),
      .rst_n     (rst_n),
      .ce        (ce),
      .str_active(str_active),
      .rd_valid  (rd_valid),
      .rd_word   (rd_word),
      .boundary  (seg_boundary),
      .words_read(seg_words)
   );

   logic ev_proc;
   logic ev_data;
   logic ev_seq;
   logic ev_ovf;
   logic ev_conf;
   logic any_ev;

   always_comb begin
      ev_proc = (proc_transfer && code_absent) || (display_update && desc_absent);
      ev_data = data_absent;
      ev_seq  = mark_access && mark_tag != odi_pkg::MARK_TAG;
      ev_ovf  = stack_top_address == stack_limit_address && !s.ovf_seen;
      ev_conf = s.test_run && test_fail;
      any_ev  = ev_proc || ev_data || ev_seq || seg_boundary || tmr_expired ||
                ev_ovf || ev_conf;
   end

   always_comb begin
      next_s = s;
      next_s.ovf_seen = stack_top_address == stack_limit_address;
      // confidence test runs only while idle with no operator busy
      next_s.test_run = proc_idle && !op_busy;
      if (s.irq_valid && report_ack) begin
         next_s.irq_valid = 1'b0;
      end
      if (!op_busy) begin
         next_s.held = 1'b0;
      end
      if (any_ev && !s.held && !s.irq_valid) begin
         next_s.held = op_busy;
         next_s.irq_valid = 1'b1;
         next_s.report = '0;
         if (ev_proc) begin
            next_s.report.cause = odi_pkg::ODI_PRESENCE_PROC;
            next_s.report.rcw_ptr = invoke_ptr;
         end else if (ev_data) begin
            next_s.report.cause = odi_pkg::ODI_PRESENCE_DATA;
            next_s.report.rcw_ptr = op_ptr;
         end else if (ev_seq) begin
            next_s.report.cause = odi_pkg::ODI_SEQUENCE;
            if (ptr_adjusted) begin
               next_s.report.p1[odi_pkg::SEQ_AFTER_BIT] = 1'b1;
            end else begin
               next_s.report.p1[odi_pkg::SEQ_BEFORE_BIT] = 1'b1;
            end
         end else if (seg_boundary) begin
            next_s.report.cause = odi_pkg::ODI_SEGMENTED;
            next_s.report.p1 = {{(odi_pkg::WORD_W-odi_pkg::CNT_W){1'b0}}, seg_words};
            next_s.report.p2 = {{(odi_pkg::WORD_W-odi_pkg::CNT_W){1'b0}},
                                str_keep_words};
         end else if (tmr_expired) begin
            next_s.report.cause = odi_pkg::ODI_TIMER;
         end else if (ev_ovf) begin
            next_s.report.cause = odi_pkg::ODI_STACK_OVF;
            next_s.report.p1 = {{(odi_pkg::WORD_W-odi_pkg::ADDR_W){1'b0}},
                                stack_limit_address};
         end else begin
            next_s.report.cause = odi_pkg::ODI_CONFIDENCE;
            next_s.report.p1 = test_detail;
            next_s.report.p2 = {{(odi_pkg::WORD_W-16){1'b0}}, op_code};
         end
      end
      // no fetch of an absent segment, no writes in a fault cycle or while a fault is held until op_busy drops
      next_s.fetch_grant = code_fetch_req && !ev_proc && !next_s.held &&
                           !(s.irq_valid && s.report.cause == odi_pkg::ODI_PRESENCE_PROC);
      next_s.write_grant = mem_write_req && !any_ev && !next_s.held;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else if (ce) begin
         s <= next_s;
      end
   end

   assign irq_valid        = s.irq_valid;
   assign report           = s.report;
   assign code_fetch_grant = s.fetch_grant;
   assign mem_write_grant  = s.write_grant;
   assign test_run         = s.test_run;

   sequence proc_miss_s;
      ce && ev_proc && !s.held && !s.irq_valid;
   endsequence

   sequence proc_report_s;
      irq_valid && report.cause == odi_pkg::ODI_PRESENCE_PROC;
   endsequence

   proc_miss_a: assert property (@(posedge mclk) disable iff (!rst_n)
      proc_miss_s |=> proc_report_s)
      else $error("procedure missing-code interrupt not raised");

   rcw_copy_a: assert property (@(posedge mclk) disable iff (!rst_n)
      proc_miss_s |=> report.rcw_ptr == $past(invoke_ptr))
      else $error("return word pointers not copied");

   no_fetch_a: assert property (@(posedge mclk) disable iff (!rst_n)
      ce && ev_proc |=> !code_fetch_grant)
      else $error("absent segment fetched");

   seq_error_a: assert property (@(posedge mclk) disable iff (!rst_n)
      ce && ev_seq && !ev_proc && !ev_data && !s.held && !s.irq_valid
      |=> report.cause == odi_pkg::ODI_SEQUENCE)
      else $error("sequence error not raised");

   seq_bits_a: assert property (@(posedge mclk) disable iff (!rst_n)
      irq_valid && report.cause == odi_pkg::ODI_SEQUENCE |->
      report.p1[odi_pkg::SEQ_AFTER_BIT] != report.p1[odi_pkg::SEQ_BEFORE_BIT])
      else $error("sequence error flags wrong");

   seg_count_a: assert property (@(posedge mclk) disable iff (!rst_n)
      seg_words <= odi_pkg::SEG_MAX_WORDS)
      else $error("segment count above limit");

   overflow_a: assert property (@(posedge mclk) disable iff (!rst_n)
      ce && ev_ovf && !s.irq_valid && !s.held |=> irq_valid)
      else $error("stack overflow not raised");

   conf_idle_a: assert property (@(posedge mclk) disable iff (!rst_n)
      ce && proc_idle && !op_busy |=> test_run)
      else $error("confidence test not started when idle");

   write_block_a: assert property (@(posedge mclk) disable iff (!rst_n)
      s.held |-> !mem_write_grant)
      else $error("write granted after fault");

   sequence take_s;
      ce && !s.held && !s.irq_valid;
   endsequence

   sequence early_quiet_s;
      !ev_proc && !ev_data && !ev_seq;
   endsequence

   sequence conf_only_s;
      !seg_boundary && !tmr_expired && !ev_ovf && ev_conf;
   endsequence

   data_miss_a: assert property (@(posedge mclk) disable iff (!rst_n)
      take_s ##0 (ev_data && !ev_proc) |=> irq_valid &&
      report.cause == odi_pkg::ODI_PRESENCE_DATA && report.rcw_ptr == $past(op_ptr))
      else $error("data miss pointers not backed up");

   seq_before_a: assert property (@(posedge mclk) disable iff (!rst_n)
      take_s ##0 (ev_seq && !ev_proc && !ev_data && !ptr_adjusted) |=>
      report.p1[odi_pkg::SEQ_BEFORE_BIT] && !report.p1[odi_pkg::SEQ_AFTER_BIT])
      else $error("sequence flag before adjust wrong");

   seq_after_a: assert property (@(posedge mclk) disable iff (!rst_n)
      take_s ##0 (ev_seq && !ev_proc && !ev_data && ptr_adjusted) |=>
      report.p1[odi_pkg::SEQ_AFTER_BIT] && !report.p1[odi_pkg::SEQ_BEFORE_BIT])
      else $error("sequence flag after adjust wrong");

   seg_cause_a: assert property (@(posedge mclk) disable iff (!rst_n)
      take_s ##0 early_quiet_s ##0 seg_boundary |=>
      irq_valid && report.cause == odi_pkg::ODI_SEGMENTED)
      else $error("segmented array interrupt not raised");

   keep_words_a: assert property (@(posedge mclk) disable iff (!rst_n)
      take_s ##0 early_quiet_s ##0 seg_boundary |=>
      report.p2[odi_pkg::CNT_W-1:0] == $past(str_keep_words))
      else $error("restart word count not reported");

   timer_cause_a: assert property (@(posedge mclk) disable iff (!rst_n)
      take_s ##0 early_quiet_s ##0 (!seg_boundary && tmr_expired) |=>
      report.cause == odi_pkg::ODI_TIMER)
      else $error("interval timer interrupt not raised");

   ovf_limit_a: assert property (@(posedge mclk) disable iff (!rst_n)
      take_s ##0 early_quiet_s ##0 (!seg_boundary && !tmr_expired && ev_ovf) |=>
      report.cause == odi_pkg::ODI_STACK_OVF &&
      report.p1[odi_pkg::ADDR_W-1:0] == $past(stack_limit_address))
      else $error("overflow report wrong");

   conf_cause_a: assert property (@(posedge mclk) disable iff (!rst_n)
      take_s ##0 early_quiet_s ##0 conf_only_s |=> report.cause == odi_pkg::ODI_CONFIDENCE)
      else $error("confidence error interrupt not raised");

   conf_detail_a: assert property (@(posedge mclk) disable iff (!rst_n)
      take_s ##0 early_quiet_s ##0 conf_only_s |=> report.p1 == $past(test_detail))
      else $error("confidence failure details not formatted");

   report_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
      irq_valid && !(ce && report_ack) |=> irq_valid && $stable(report))
      else $error("report changed before acknowledge");

   ack_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
      ce && irq_valid && report_ack |=> !irq_valid)
      else $error("report not cleared by acknowledge");

   held_drop_a: assert property (@(posedge mclk) disable iff (!rst_n)
      ce && s.held && op_busy && !irq_valid |=> !irq_valid)
      else $error("second condition reported in one operator");

   write_fault_a: assert property (@(posedge mclk) disable iff (!rst_n)
      ce && any_ev |=> !mem_write_grant)
      else $error("write granted with fault");

   test_busy_a: assert property (@(posedge mclk) disable iff (!rst_n)
      ce && op_busy |=> !test_run)
      else $error("confidence test ran during operator");

   proc_fetch_a: assert property (@(posedge mclk) disable iff (!rst_n)
      irq_valid && report.cause == odi_pkg::ODI_PRESENCE_PROC |-> !code_fetch_grant)
      else $error("absent segment fetch granted");
endmodule

// ==== hw/odi_interval_timer.sv ====
// odi_interval_timer: preset-and-count-up interval timer
// assumes the operator decode presents the operator code with a one-cycle strobe
`timescale 1ns/1ps
module odi_interval_timer (
   // clock and reset
   input  wire logic                        mclk,
   input  wire logic                        rst_n,
   input  wire logic                        ce,
   // operator strobe
   input  wire logic                        op_valid,
   input  wire logic [15:0]                 op_code,
   input  wire logic [odi_pkg::TIMER_W-1:0] preset,
   // expiry
   output logic                             expired
);
   typedef struct packed {
      logic                        run;
      logic [odi_pkg::TIMER_W-1:0] count;
      logic                        expired;
   } odi_tmr_state_t;

   odi_tmr_state_t s;
   odi_tmr_state_t next_s;

   always_comb begin
      next_s = s;
      next_s.expired = 1'b0;
      if (op_valid && op_code == odi_pkg::SET_TIMER_CODE) begin
         next_s.run = 1'b1;
         next_s.count = preset;
      end else if (s.run) begin
         if (s.count == odi_pkg::TIMER_MAX) begin
            next_s.run = 1'b0;
            next_s.expired = 1'b1;
         end else begin
            next_s.count = s.count + 1'b1;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else if (ce) begin
         s <= next_s;
      end
   end

   assign expired = s.expired;

   timer_expiry_a: assert property (@(posedge mclk) disable iff (!rst_n)
      ce && s.run && s.count == odi_pkg::TIMER_MAX && !(op_valid &&
      op_code == odi_pkg::SET_TIMER_CODE) |=> expired)
      else $error("timer did not expire at maximum count");
endmodule

// ==== hw/odi_pkg.sv ====
// odi_pkg: shared constants and carrier types for operator-dependent interrupt detect
// assumes a 48-bit data word plus the memory-protect bit, and one processor clock
package odi_pkg;
   localparam int WORD_W        = 48;
   localparam int PTR_W         = 13;
   localparam int SYL_W         = 3;
   localparam int ADDR_W        = 20;
   localparam int TIMER_W       = 16;
   localparam int CNT_W         = 9;
   localparam int TAG_W         = 3;
   // tag value of a stack link mark word
   localparam logic [TAG_W-1:0] MARK_TAG = 3'h3;
   // memory-protect bit position in a read word
   localparam int PROTECT_BIT   = 48;
   // sequence error flags in the first parameter word
   localparam int SEQ_BEFORE_BIT = 24;
   localparam int SEQ_AFTER_BIT  = 23;
   // largest string segment in data words
   localparam logic [CNT_W-1:0] SEG_MAX_WORDS = 9'h100;
   // operator code of the set-interval-timer operator
   localparam logic [15:0] SET_TIMER_CODE = 16'h9545;
   localparam logic [TIMER_W-1:0] TIMER_MAX = 16'hFFFF;
   localparam logic [TIMER_W-1:0] TIMER_RESET = 16'h0000;

   typedef enum logic [3:0] {
      ODI_NONE,
      ODI_PRESENCE_PROC,
      ODI_PRESENCE_DATA,
      ODI_SEQUENCE,
      ODI_SEGMENTED,
      ODI_TIMER,
      ODI_STACK_OVF,
      ODI_CONFIDENCE
   } odi_cause_t;

   // pointers of a control word
   typedef struct packed {
      logic [PTR_W-1:0] iwp;
      logic [SYL_W-1:0] syl;
   } odi_ptr_t;

   // interrupt report to the stack-building logic
   typedef struct packed {
      odi_cause_t        cause;
      logic [WORD_W-1:0] p1;
      logic [WORD_W-1:0] p2;
      odi_ptr_t          rcw_ptr;
   } odi_report_t;
endpackage

// ==== hw/odi_segment_check.sv ====
// odi_segment_check: memory-protect boundary check during string operations
// assumes one read-valid strobe per word read by the string datapath
`timescale 1ns/1ps
module odi_segment_check (
   // clock and reset
   input  wire logic                       mclk,
   input  wire logic                       rst_n,
   input  wire logic                       ce,
   // string reads
   input  wire logic                       str_active,
   input  wire logic                       rd_valid,
   input  wire logic [odi_pkg::WORD_W:0]   rd_word,
   // results
   output logic                            boundary,
   output logic [odi_pkg::CNT_W-1:0]       words_read
);
   typedef struct packed {
      logic [odi_pkg::CNT_W-1:0] count;
   } odi_seg_state_t;

   odi_seg_state_t s;
   odi_seg_state_t next_s;

   always_comb begin
      next_s = s;
      if (!str_active) begin
         next_s.count = '0;
      end else if (rd_valid && !rd_word[odi_pkg::PROTECT_BIT] &&
                   s.count != odi_pkg::SEG_MAX_WORDS) begin
         next_s.count = s.count + 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else if (ce) begin
         s <= next_s;
      end
   end

   // link word with protect bit set closes the segment
   assign boundary = str_active && rd_valid && rd_word[odi_pkg::PROTECT_BIT];
   assign words_read = s.count;
endmodule
